// ===== dom_pkg.sv
/*
  Shared constants for the eight-channel digital output monitor: register
  numbers, frame offsets, function models, reset values and timing counts.
  Assumes a single 200 MHz system clock on both ends of the link.
*/
package dom_pkg;

  localparam int          CLK_MHZ            = 200;
  localparam int          NUM_CH             = 8;
  localparam logic [7:0]  REG_OUTPUT_SWITCH  = 8'h02;
  localparam logic [7:0]  REG_CHANNEL_FAULT  = 8'h1e;
  localparam logic [3:0]  FRM_OFS_OUTPUT     = 4'h0;
  localparam logic [3:0]  FRM_OFS_STATUS     = 4'h1;
  localparam logic [3:0]  BC_OFS_OUTPUT      = 4'h0;
  localparam logic [7:0]  MODEL_STANDARD     = 8'h00;
  localparam logic [7:0]  MODEL_BUS_CTRL     = 8'hfe;
  localparam logic [7:0]  OUTPUT_RESET       = 8'h00;
  localparam logic [7:0]  FAULT_RESET        = 8'h00;
  localparam int          LOGICAL_SLOTS      = 1;
  // Sync to output delay, below the 60 us ceiling.
  localparam int          APPLY_DELAY_NS     = 2000;
  localparam int          APPLY_DELAY_CYC    =
    (APPLY_DELAY_NS * CLK_MHZ) / 1000;
  localparam int          MAX_DELAY_US       = 60;
  // Shortest bus cycle the controller may use.
  localparam int          MIN_CYCLE_US       = 100;
  localparam int          MIN_CYCLE_CYC      = MIN_CYCLE_US * CLK_MHZ;
  // Settle time before a sensed mismatch counts as a fault.
  localparam int          SETTLE_NS          = 1000;
  localparam int          SETTLE_CYC         = (SETTLE_NS * CLK_MHZ) / 1000;

endpackage

// ===== dom_link_if.sv
/*
  Link between the bus controller end and the output module end: cyclic
  frame slots, acyclic register accesses, cycle sync and fault events.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface dom_link_if;
  logic       sync_p;
  logic       model_bc;
  logic       cyc_wr_vld;
  logic [3:0] cyc_wr_ofs;
  logic [7:0] cyc_wr_data;
  logic       cyc_rd_req;
  logic [3:0] cyc_rd_ofs;
  logic       cyc_rd_vld;
  logic [7:0] cyc_rd_data;
  logic       acy_req;
  logic       acy_wr;
  logic [7:0] acy_reg;
  logic [7:0] acy_wdata;
  logic       acy_ack;
  logic       acy_err;
  logic [7:0] acy_rdata;
  logic       fault_evt;

  modport ctrl (output sync_p, model_bc, cyc_wr_vld, cyc_wr_ofs,
                cyc_wr_data, cyc_rd_req, cyc_rd_ofs, acy_req, acy_wr,
                acy_reg, acy_wdata,
                input cyc_rd_vld, cyc_rd_data, acy_ack, acy_err,
                acy_rdata, fault_evt);
  modport dev  (input sync_p, model_bc, cyc_wr_vld, cyc_wr_ofs,
                cyc_wr_data, cyc_rd_req, cyc_rd_ofs, acy_req, acy_wr,
                acy_reg, acy_wdata,
                output cyc_rd_vld, cyc_rd_data, acy_ack, acy_err,
                acy_rdata, fault_evt);
endinterface

// ===== dom_device.sv
/*
  Output module end: latches the switching byte, applies it a fixed delay
  after the cycle sync, monitors each channel and reports fault changes.
  Assumes link inputs and sensed pins are synchronous to clk_sys.
*/
`timescale 1ns/1ps
//
// Contract
// - Bit n drives output n+1, one on.
// - Apply outputs fixed delay after sync, <60us.
// - Compare sensed state to driven command.
// - Command change restarts that channel's monitor.
// - Status change raises unsolicited fault event.
// - Fault on overload, no supply, or backfeed.
// - Eight fault bits in one status byte.
// - Standard model: write offset 0, read 1.
// - Acyclic numbers: 2 output, 30 status.
// - Bus-controller model: write 0, status acyclic.
// - Controller cycle at least 100 us.
// - Full output update every bus cycle.
// - Packing option is controller-side only.
// - Module occupies one logical slot.
module dom_device
  import dom_pkg::*;
#(
  parameter int NCH         = NUM_CH,
  parameter int APPLY_CYC   = APPLY_DELAY_CYC,
  parameter int SETTLE_CYCS = SETTLE_CYC
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_b,
  dom_link_if.dev             link,
  input  wire logic [NCH-1:0] sense_level,
  input  wire logic [NCH-1:0] overload,
  input  wire logic           io_supply_ok,
  output logic      [NCH-1:0] drive_out
);

  typedef enum logic [1:0] {DOM_IDLE, DOM_WAIT} dom_apply_t;

  dom_apply_t     st_q, st_d;
  logic [15:0]    dly_q, dly_d;
  logic [NCH-1:0] cmd_q, cmd_d;
  logic [NCH-1:0] out_q, out_d;
  logic [NCH-1:0] flt_q, flt_d;
  logic [NCH-1:0] set_q, set_d;
  logic [7:0]     settle_q [NCH];
  logic [7:0]     settle_d [NCH];
  logic           evt_q, evt_d;
  logic           rvld_q, rvld_d;
  logic [7:0]     rdat_q, rdat_d;
  logic           ack_q, ack_d;
  logic           aerr_q, aerr_d;
  logic [7:0]     adat_q, adat_d;
  logic           cyc_out_wr;
  logic           acy_out_wr;

  // Cyclic write of the output byte sits at offset 0 in either model.
  assign cyc_out_wr = link.cyc_wr_vld &&
                      (link.model_bc ? link.cyc_wr_ofs == BC_OFS_OUTPUT
                                     : link.cyc_wr_ofs == FRM_OFS_OUTPUT);
  assign acy_out_wr = link.acy_req && link.acy_wr &&
                      link.acy_reg == REG_OUTPUT_SWITCH;

  always_comb
  begin
    cmd_d = cmd_q;
    if (cyc_out_wr)
      cmd_d = link.cyc_wr_data[NCH-1:0];
    else if (acy_out_wr)
      cmd_d = link.acy_wdata[NCH-1:0];
  end

  // Apply the latched command a fixed count after each sync.
  always_comb
  begin
    st_d  = st_q;
    dly_d = dly_q;
    out_d = out_q;
    case (st_q)
      DOM_IDLE:
        if (link.sync_p)
        begin
          st_d  = DOM_WAIT;
          dly_d = 16'(APPLY_CYC - 1);
        end
      DOM_WAIT:
        if (dly_q == 16'h0000)
        begin
          out_d = cmd_q;
          st_d  = DOM_IDLE;
        end
        else
          dly_d = dly_q - 16'h0001;
      default:
        st_d = DOM_IDLE;
    endcase
  end

  // Per channel monitor against the driven state.
  always_comb
  begin
    flt_d = flt_q;
    set_d = set_q;
    for (int i = 0; i < NCH; i++)
    begin
      settle_d[i] = settle_q[i];
      if (out_d[i] != out_q[i])
      begin
        settle_d[i] = 8'(SETTLE_CYCS);
        set_d[i]    = 1'b0;
        flt_d[i]    = 1'b0;
      end
      else if (!set_q[i])
      begin
        if (settle_q[i] == 8'h00)
          set_d[i] = 1'b1;
        else
          settle_d[i] = settle_q[i] - 8'h01;
      end
      else
        flt_d[i] = overload[i] ||
                   (out_q[i] && !io_supply_ok) ||
                   (sense_level[i] != out_q[i]);
    end
  end

  assign evt_d = (flt_d != flt_q);

  // Cyclic status read at frame offset 1 only in the standard model.
  always_comb
  begin
    rvld_d = 1'b0;
    rdat_d = rdat_q;
    if (link.cyc_rd_req && !link.model_bc &&
        link.cyc_rd_ofs == FRM_OFS_STATUS)
    begin
      rvld_d = 1'b1;
      rdat_d = 8'(flt_q);
    end
  end

  // Acyclic access by register number; anything else is refused.
  always_comb
  begin
    ack_d  = 1'b0;
    aerr_d = 1'b0;
    adat_d = adat_q;
    if (link.acy_req)
    begin
      ack_d = 1'b1;
      if (!link.acy_wr && link.acy_reg == REG_CHANNEL_FAULT)
        adat_d = 8'(flt_q);
      else if (!acy_out_wr)
        aerr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q   <= DOM_IDLE;
      dly_q  <= 16'h0000;
      cmd_q  <= OUTPUT_RESET;
      out_q  <= OUTPUT_RESET;
      flt_q  <= FAULT_RESET;
      set_q  <= '0;
      for (int i = 0; i < NCH; i++)
        settle_q[i] <= 8'h00;
      evt_q  <= 1'b0;
      rvld_q <= 1'b0;
      rdat_q <= 8'h00;
      ack_q  <= 1'b0;
      aerr_q <= 1'b0;
      adat_q <= 8'h00;
    end
    else
    begin
      st_q   <= st_d;
      dly_q  <= dly_d;
      cmd_q  <= cmd_d;
      out_q  <= out_d;
      flt_q  <= flt_d;
      set_q  <= set_d;
      settle_q <= settle_d;
      evt_q  <= evt_d;
      rvld_q <= rvld_d;
      rdat_q <= rdat_d;
      ack_q  <= ack_d;
      aerr_q <= aerr_d;
      adat_q <= adat_d;
    end
  end

  assign drive_out        = out_q;
  assign link.fault_evt   = evt_q;
  assign link.cyc_rd_vld  = rvld_q;
  assign link.cyc_rd_data = rdat_q;
  assign link.acy_ack     = ack_q;
  assign link.acy_err     = aerr_q;
  assign link.acy_rdata   = adat_q;

endmodule // dom_device

// ===== dom_controller.sv
/*
  Bus controller end: emits the cycle sync every CYCLE_CYC clocks, the minimum
  cycle by default, writes the output byte each cycle, reads status cyclically in the
  standard model and acyclically on request or on a fault event.
  Assumes user inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module dom_controller
  import dom_pkg::*;
#(
  parameter int CYCLE_CYC = MIN_CYCLE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  dom_link_if.ctrl        link,
  input  wire logic       model_bc_sel,
  input  wire logic [7:0] out_byte,
  input  wire logic       status_poll,
  output logic      [7:0] status_byte,
  output logic            status_upd,
  output logic            fault_seen
);

  logic [31:0] cnt_q, cnt_d;
  logic        pend_q, pend_d;
  logic        busy_q, busy_d;
  logic [7:0]  stat_q, stat_d;
  logic        upd_q, upd_d;
  logic        seen_q, seen_d;
  logic        sync;

  // Cycle period is CYCLE_CYC clocks, the minimum cycle time by default.
  assign sync = (cnt_q == 32'h0);

  always_comb
  begin
    cnt_d  = sync ? 32'(CYCLE_CYC - 1) : cnt_q - 32'h1;
    pend_d = pend_q || status_poll || link.fault_evt;
    busy_d = busy_q;
    stat_d = stat_q;
    upd_d  = 1'b0;
    seen_d = seen_q || link.fault_evt;
    if (!busy_q && pend_q)
    begin
      busy_d = 1'b1;
      pend_d = status_poll || link.fault_evt;
    end
    else if (busy_q && link.acy_ack)
    begin
      busy_d = 1'b0;
      if (!link.acy_err)
      begin
        stat_d = link.acy_rdata;
        upd_d  = 1'b1;
      end
    end
    if (link.cyc_rd_vld)
    begin
      stat_d = link.cyc_rd_data;
      upd_d  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q  <= 32'h0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      stat_q <= FAULT_RESET;
      upd_q  <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      stat_q <= stat_d;
      upd_q  <= upd_d;
      seen_q <= seen_d;
    end
  end

  assign link.sync_p      = sync;
  assign link.model_bc    = model_bc_sel;
  // Output byte written in the sync cycle at offset 0.
  assign link.cyc_wr_vld  = sync;
  assign link.cyc_wr_ofs  = model_bc_sel ? BC_OFS_OUTPUT : FRM_OFS_OUTPUT;
  assign link.cyc_wr_data = out_byte;
  assign link.cyc_rd_req  = sync && !model_bc_sel;
  assign link.cyc_rd_ofs  = FRM_OFS_STATUS;
  assign link.acy_req     = busy_q && !link.acy_ack;
  assign link.acy_wr      = 1'b0;
  assign link.acy_reg     = REG_CHANNEL_FAULT;
  assign link.acy_wdata   = 8'h00;
  assign status_byte      = stat_q;
  assign status_upd       = upd_q;
  assign fault_seen       = seen_q;

endmodule // dom_controller

// ===== dom_link_sva.sv
/*
  Assertions on the link between controller end and output module end.
  Assumes one clock and is instantiated beside the link interface.
*/
`timescale 1ns/1ps
module dom_link_sva
  import dom_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       sync_p,
  input wire logic       model_bc,
  input wire logic       cyc_wr_vld,
  input wire logic [3:0] cyc_wr_ofs,
  input wire logic       cyc_rd_req,
  input wire logic [3:0] cyc_rd_ofs,
  input wire logic       cyc_rd_vld,
  input wire logic       acy_req,
  input wire logic       acy_wr,
  input wire logic [7:0] acy_reg,
  input wire logic       acy_ack,
  input wire logic       acy_err
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_rd_answer: assert property (cyc_rd_req && !model_bc &&
    cyc_rd_ofs == FRM_OFS_STATUS |=> cyc_rd_vld) else $error("no read data");
  a_rd_offset: assert property (cyc_rd_req |->
    cyc_rd_ofs == FRM_OFS_STATUS) else $error("bad read offset");
  a_wr_offset: assert property (cyc_wr_vld |->
    cyc_wr_ofs == BC_OFS_OUTPUT) else $error("bad write offset");
  a_bc_no_read: assert property (model_bc |-> !cyc_rd_req)
    else $error("cyclic read in bus-controller model");
  a_bc_no_vld: assert property (model_bc && $past(model_bc)
    |-> !cyc_rd_vld) else $error("cyclic answer in bus-controller model");
  a_acy_ack_next: assert property (acy_req |=> acy_ack)
    else $error("acyclic access not answered");
  a_acy_status_ok: assert property (acy_req && !acy_wr &&
    acy_reg == REG_CHANNEL_FAULT |=> !acy_err) else $error("status refused");
  a_acy_ack_pulse: assert property (acy_ack |=> !acy_ack)
    else $error("acyclic answer too long");
  a_sync_spacing: assert property (sync_p |=> !sync_p [*5])
    else $error("sync too close");
endmodule // dom_link_sva

// ===== dom_tb.sv
/*
  Testbench joining controller end and output module end over the link.
  Assumes short simulation counts for bus cycle, apply delay and settle.
*/
`timescale 1ns/1ps
module dom_tb
  import dom_pkg::*;
;
  localparam int APPLY = 4;
  logic       clk_sys      = 1'b0;
  logic       rst_b        = 1'b0;
  logic       model_bc_sel = 1'b0;
  logic       status_poll  = 1'b0;
  logic       io_supply_ok = 1'b1;
  logic [7:0] out_byte     = 8'h00;
  logic [7:0] overload     = 8'h00;
  logic [7:0] ext_v        = 8'h00;
  logic [7:0] cur          = 8'h00;
  logic [7:0] sense_level;
  logic [7:0] drive_out;
  logic [7:0] status_byte;
  logic       status_upd;
  logic       fault_seen;
  int         n_fail       = 0;
  int         compares     = 0;

  always #2.5 clk_sys = ~clk_sys;
  // The pin reads high when driven or when an outside source feeds it.
  assign sense_level = drive_out | ext_v;

  dom_link_if link ();
  dom_device #(.APPLY_CYC(APPLY), .SETTLE_CYCS(3)) dom_device_inst (
    .clk_sys, .rst_b, .link, .sense_level, .overload, .io_supply_ok,
    .drive_out);
  dom_controller #(.CYCLE_CYC(40)) dom_controller_inst (
    .clk_sys, .rst_b, .link, .model_bc_sel, .out_byte, .status_poll,
    .status_byte, .status_upd, .fault_seen);
  dom_link_sva dom_link_sva_inst (.clk_sys, .rst_b,
    .sync_p(link.sync_p), .model_bc(link.model_bc),
    .cyc_wr_vld(link.cyc_wr_vld), .cyc_wr_ofs(link.cyc_wr_ofs),
    .cyc_rd_req(link.cyc_rd_req), .cyc_rd_ofs(link.cyc_rd_ofs),
    .cyc_rd_vld(link.cyc_rd_vld), .acy_req(link.acy_req),
    .acy_wr(link.acy_wr), .acy_reg(link.acy_reg),
    .acy_ack(link.acy_ack), .acy_err(link.acy_err));

  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wait_sync;
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 100 && link.sync_p !== 1'b1; i++)
      @(negedge clk_sys);
    chk("sync_p", 8'h01, {7'h00, link.sync_p});
    if (i == 100)
      end_sim();
  endtask

  // Commands a new byte between syncs, then checks it lands exactly APPLY+1
  // rising edges after the sync whose cyclic write carries it.
  task automatic apply(input logic [7:0] v);
    wait_sync();
    @(negedge clk_sys);
    out_byte = v;
    wait_sync();
    repeat (APPLY) @(negedge clk_sys);
    chk("drive_out", cur, drive_out);
    @(negedge clk_sys);
    chk("drive_out", v, drive_out);
    cur = v;
  endtask

  task automatic wait_stat(input logic [7:0] exp);
    int i;
    for (i = 0; i < 300 && status_byte !== exp; i++)
      @(negedge clk_sys);
    chk("status_byte", exp, status_byte);
    if (i == 300)
      end_sim();
  endtask

  task automatic wait_upd;
    int i;
    for (i = 0; i < 20 && status_upd !== 1'b1; i++)
      @(negedge clk_sys);
    chk("status_upd", 8'h01, {7'h00, status_upd});
    if (i == 20)
      end_sim();
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("drive_out", OUTPUT_RESET, drive_out);
    chk("status_byte", FAULT_RESET, status_byte);
    chk("fault_seen", 8'h00, {7'h00, fault_seen});
    apply(8'ha5);
    apply(8'h5a);
    overload = 8'h08;
    wait_stat(8'h08);
    chk("fault_seen", 8'h01, {7'h00, fault_seen});
    overload = 8'h00;
    wait_stat(8'h00);
    io_supply_ok = 1'b0;
    wait_stat(8'h5a);
    io_supply_ok = 1'b1;
    ext_v = 8'h81;
    wait_stat(8'h81);
    apply(8'h5b);
    wait_stat(8'h80);
    ext_v = 8'h00;
    wait_stat(8'h00);
    model_bc_sel = 1'b1;
    apply(8'h3c);
    overload = 8'h04;
    wait_stat(8'h04);
    overload = 8'h00;
    wait_stat(8'h00);
    status_poll = 1'b1;
    @(negedge clk_sys);
    status_poll = 1'b0;
    wait_upd();
    wait_stat(8'h00);
    end_sim();
  end
endmodule // dom_tb
